// *** verilog/ubcl_locator.sv ***
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Operation
// - save command records unbalance and reference phasors
// - unbalance always taken relative to reference phase
// - stored natural unbalance subtracted from each measurement
// - location timeout recompensates in location mode, no trip from timer; in normal mode it trips
// - location recompensation leaves normal stage untouched
// - failure angle selects one of six counters
// - allowed fault count settable, next one trips
// - sixty degrees leading counts branch two phase two
// - mode off, normal or location; only location locates
// - command clears all location counters
// - start value 0.01 to 20.0 pu, 0.01 steps
// - operate time 0.04 to 300 s, 0.01 s steps
module ubcl_locator
    import ubcl_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES,
    parameter int PU_SHIFT = 8
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire ubcl_phasor_type unbalance_current_input,
    input wire ubcl_phasor_type reference_phase_current,
    input wire logic sample_valid,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic normal_start,
    output logic normal_trip,
    output logic location_start,
    output logic location_trip
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [SET_W-1:0] clamp(
        input logic [SET_W-1:0] v,
        input logic [SET_W-1:0] lo,
        input logic [SET_W-1:0] hi
    );
        logic [SET_W-1:0] r;
        r = v;
        if (v < lo)
            r = lo;
        else if (v > hi)
            r = hi;
        return r;
    endfunction : clamp

    function automatic logic [MAG_W-1:0] mag_est(input ubcl_rel_type p);
        logic [REL_W-1:0] a;
        logic [REL_W-1:0] b;
        logic [REL_W-1:0] hi;
        logic [REL_W-1:0] lo;
        a = p.re[REL_W-1] ? REL_W'(-p.re) : p.re;
        b = p.im[REL_W-1] ? REL_W'(-p.im) : p.im;
        hi = (a > b) ? a : b;
        lo = (a > b) ? b : a;
        // max plus half min: cheap, within about 12 percent
        return MAG_W'(hi) + MAG_W'(lo >> 1);
    endfunction : mag_est

    function automatic logic [2:0] sector(input ubcl_rel_type p);
        logic [REL_W-1:0] a;
        logic [REL_W-1:0] b;
        logic [REL_W+9:0] ya;
        logic [REL_W+9:0] xa;
        logic [2:0] s;
        a = p.re[REL_W-1] ? REL_W'(-p.re) : p.re;
        b = p.im[REL_W-1] ? REL_W'(-p.im) : p.im;
        ya = (REL_W+10)'(b) * (REL_W+10)'(SQRT3_NUM);
        xa = (REL_W+10)'(a) * (REL_W+10)'(SQRT3_DEN);
        // centres at k*60 deg, edges at 30 + k*60 deg
        if (ya < xa)
            s = p.re[REL_W-1] ? 3'h3 : 3'h0;
        else if (!p.im[REL_W-1])
            s = p.re[REL_W-1] ? 3'h2 : 3'h1;
        else
            s = p.re[REL_W-1] ? 3'h4 : 3'h5;
        return s;
    endfunction : sector

    // ****************************************************************
    // registers
    // ****************************************************************
    ubcl_mode_type mode_q;
    logic [SET_W-1:0] norm_start_q;
    logic [SET_W-1:0] norm_time_q;
    logic [SET_W-1:0] loc_start_q;
    logic [SET_W-1:0] loc_time_q;
    logic [CNT_W-1:0] max_faults_q;
    ubcl_rel_type rel_q;
    ubcl_rel_type nat_q;
    ubcl_rel_type loc_ref_q;
    ubcl_rel_type norm_comp_q;
    ubcl_rel_type loc_comp_q;
    logic [CNT_W-1:0] cnt_q [NUM_SECT];
    logic [TOT_W-1:0] total_q;
    logic [31:0] step_q;
    logic [SET_W-1:0] norm_tmr_q;
    logic [SET_W-1:0] loc_tmr_q;
    logic norm_trip_q;
    logic loc_trip_q;
    logic norm_start_q2;
    logic loc_start_q2;
    logic [31:0] rdata_q;
    logic valid_q;

    // ****************************************************************
    // phasor path
    // ****************************************************************
    wire ubcl_rel_type rel_d;
    wire ubcl_rel_type norm_comp_d;
    wire ubcl_rel_type loc_comp_d;
    wire [MAG_W-1:0] norm_mag;
    wire [MAG_W-1:0] loc_mag;
    wire norm_above;
    wire loc_above;

    // unbalance times conjugate of reference: rotation follows the
    // reference, so frequency drift cancels out
    assign rel_d.re = REL_W'(unbalance_current_input.re
        * reference_phase_current.re) + REL_W'(unbalance_current_input.im
        * reference_phase_current.im);
    assign rel_d.im = REL_W'(unbalance_current_input.im
        * reference_phase_current.re) - REL_W'(unbalance_current_input.re
        * reference_phase_current.im);
    assign norm_comp_d.re = rel_q.re - nat_q.re;
    assign norm_comp_d.im = rel_q.im - nat_q.im;
    assign loc_comp_d.re = rel_q.re - loc_ref_q.re;
    assign loc_comp_d.im = rel_q.im - loc_ref_q.im;
    assign norm_mag = mag_est(norm_comp_q);
    assign loc_mag = mag_est(loc_comp_q);
    assign norm_above = (mode_q != UBCL_MODE_OFF)
        && (norm_mag >= (MAG_W'(norm_start_q) << PU_SHIFT));
    assign loc_above = (mode_q != UBCL_MODE_OFF)
        && (loc_mag >= (MAG_W'(loc_start_q) << PU_SHIFT));

    // ****************************************************************
    // decoding
    // ****************************************************************
    wire step_tick;
    wire save_cmd;
    wire clear_cmd;
    wire locating;
    wire loc_expire;
    wire norm_expire;
    wire [2:0] fault_sect;
    wire [TOT_W-1:0] total_next;

    assign step_tick = (step_q == 32'(STEP_CYC - 1));
    assign save_cmd = wr && (addr == REG_CMD) && wdata[CMD_SAVE_BIT];
    assign clear_cmd = wr && (addr == REG_CMD) && wdata[CMD_CLEAR_BIT];
    assign locating = (mode_q == UBCL_MODE_LOCATION);
    assign norm_expire = norm_above && step_tick
        && (norm_tmr_q + 16'h0001 >= norm_time_q);
    assign loc_expire = loc_above && step_tick
        && (loc_tmr_q + 16'h0001 >= loc_time_q);
    assign fault_sect = sector(loc_comp_q);
    assign total_next = total_q + 5'h01;

    // ****************************************************************
    // settings
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mode_q <= UBCL_MODE_OFF;
            norm_start_q <= START_MAX;
            norm_time_q <= TIME_MAX;
            loc_start_q <= START_MAX;
            loc_time_q <= TIME_MAX;
            max_faults_q <= MAX_FAULTS_RST;
        end
        else if (wr)
        begin
            case (addr)
                REG_MODE:
                    mode_q <= ubcl_mode_type'(wdata[1:0]);
                REG_NORM_START:
                    norm_start_q <= clamp(wdata[SET_W-1:0], START_MIN,
                        START_MAX);
                REG_NORM_TIME:
                    norm_time_q <= clamp(wdata[SET_W-1:0], TIME_MIN,
                        TIME_MAX);
                REG_LOC_START:
                    loc_start_q <= clamp(wdata[SET_W-1:0], START_MIN,
                        START_MAX);
                REG_LOC_TIME:
                    loc_time_q <= clamp(wdata[SET_W-1:0], TIME_MIN,
                        TIME_MAX);
                REG_MAX_FAULTS:
                    max_faults_q <= wdata[CNT_W-1:0];
                default:
                    mode_q <= mode_q;
            endcase
        end
    end

    // ****************************************************************
    // measurement and compensation
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rel_q <= '0;
            valid_q <= 1'b0;
            norm_comp_q <= '0;
            loc_comp_q <= '0;
        end
        else
        begin
            valid_q <= sample_valid;
            if (sample_valid)
                rel_q <= rel_d;
            if (valid_q)
            begin
                norm_comp_q <= norm_comp_d;
                loc_comp_q <= loc_comp_d;
            end
        end
    end

    // natural unbalance saved only on an explicit command; location reference also on recompensation
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            nat_q <= '0;
            loc_ref_q <= '0;
        end
        else if (save_cmd)
        begin
            nat_q <= rel_q;
            loc_ref_q <= rel_q;
        end
        else if (loc_expire && locating)
            loc_ref_q <= rel_q;
    end

    // ****************************************************************
    // definite time stages
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
            step_q <= '0;
        else if (step_tick)
            step_q <= '0;
        else
            step_q <= step_q + 32'h00000001;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            norm_tmr_q <= '0;
            loc_tmr_q <= '0;
            norm_start_q2 <= 1'b0;
            loc_start_q2 <= 1'b0;
        end
        else
        begin
            norm_start_q2 <= norm_above;
            loc_start_q2 <= loc_above;
            if (!norm_above)
                norm_tmr_q <= '0;
            else if (step_tick && norm_tmr_q != norm_time_q)
                norm_tmr_q <= norm_tmr_q + 16'h0001;
            // recompensation restarts the wait for the next element
            if (!loc_above || (loc_expire && locating))
                loc_tmr_q <= '0;
            else if (step_tick && loc_tmr_q != loc_time_q)
                loc_tmr_q <= loc_tmr_q + 16'h0001;
        end
    end

    // ****************************************************************
    // fault location counters and trips
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn || clear_cmd)
        begin
            for (int i = 0; i < NUM_SECT; i++)
                cnt_q[i] <= '0;
            total_q <= '0;
        end
        else if (loc_expire && locating)
        begin
            if (cnt_q[fault_sect] != {CNT_W{1'b1}})
                cnt_q[fault_sect] <= cnt_q[fault_sect] + 4'h1;
            if (total_q != {TOT_W{1'b1}})
                total_q <= total_next;
        end
    end

    // trips latch until cleared or mode off; a new trip beats a clear
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            norm_trip_q <= 1'b0;
            loc_trip_q <= 1'b0;
        end
        else
        begin
            if (norm_expire)
                norm_trip_q <= 1'b1;
            else if (clear_cmd || mode_q == UBCL_MODE_OFF)
                norm_trip_q <= 1'b0;
            if (loc_expire && locating
                && total_next > TOT_W'(max_faults_q))
                loc_trip_q <= 1'b1;
            else if (loc_expire && mode_q == UBCL_MODE_NORMAL)
                loc_trip_q <= 1'b1;
            else if (clear_cmd || mode_q == UBCL_MODE_OFF)
                loc_trip_q <= 1'b0;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        case (addr)
            REG_MODE: rd_mux = 32'(mode_q);
            REG_NORM_START: rd_mux = 32'(norm_start_q);
            REG_NORM_TIME: rd_mux = 32'(norm_time_q);
            REG_LOC_START: rd_mux = 32'(loc_start_q);
            REG_LOC_TIME: rd_mux = 32'(loc_time_q);
            REG_MAX_FAULTS: rd_mux = 32'(max_faults_q);
            REG_STATUS: rd_mux = {24'h000000, 3'h0, total_q} << 4
                | 32'({loc_trip_q, loc_start_q2, norm_trip_q,
                       norm_start_q2});
            REG_COUNTERS: rd_mux = {8'h00, cnt_q[5], cnt_q[4], cnt_q[3],
                cnt_q[2], cnt_q[1], cnt_q[0]};
            REG_COMP_RE: rd_mux = 32'(norm_comp_q.re >>> PU_SHIFT);
            REG_COMP_IM: rd_mux = 32'(norm_comp_q.im >>> PU_SHIFT);
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            rdata_q <= '0;
        else if (rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= '0;
    end

    assign rdata = rdata_q;
    assign normal_start = norm_start_q2;
    assign normal_trip = norm_trip_q;
    assign location_start = loc_start_q2;
    assign location_trip = loc_trip_q;

endmodule : ubcl_locator

// *** verilog/ubcl_pkg.sv ***
package ubcl_pkg;

    // ****************************************************************
    // phasor carrier
    // ****************************************************************
    localparam int PH_W = 16;
    localparam int REL_W = 2 * PH_W + 1;
    localparam int MAG_W = REL_W + 1;

    typedef struct packed {
        logic signed [PH_W-1:0] re;
        logic signed [PH_W-1:0] im;
    } ubcl_phasor_type;

    typedef struct packed {
        logic signed [REL_W-1:0] re;
        logic signed [REL_W-1:0] im;
    } ubcl_rel_type;

    // ****************************************************************
    // modes and register map (word index on the plain port)
    // ****************************************************************
    typedef enum logic [1:0] {
        UBCL_MODE_OFF = 2'b00,
        UBCL_MODE_NORMAL = 2'b01,
        UBCL_MODE_LOCATION = 2'b10
    } ubcl_mode_type;

    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CMD = 4'h1;
    localparam logic [ADDR_W-1:0] REG_NORM_START = 4'h2;
    localparam logic [ADDR_W-1:0] REG_NORM_TIME = 4'h3;
    localparam logic [ADDR_W-1:0] REG_LOC_START = 4'h4;
    localparam logic [ADDR_W-1:0] REG_LOC_TIME = 4'h5;
    localparam logic [ADDR_W-1:0] REG_MAX_FAULTS = 4'h6;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;
    localparam logic [ADDR_W-1:0] REG_COUNTERS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_COMP_RE = 4'h9;
    localparam logic [ADDR_W-1:0] REG_COMP_IM = 4'hA;

    localparam int CMD_SAVE_BIT = 0;
    localparam int CMD_CLEAR_BIT = 1;

    // ****************************************************************
    // settings: start in 0.01 pu, time in 0.01 s steps
    // ****************************************************************
    localparam int SET_W = 16;
    localparam logic [SET_W-1:0] START_MIN = 16'h0001;
    localparam logic [SET_W-1:0] START_MAX = 16'h07D0;
    localparam logic [SET_W-1:0] TIME_MIN = 16'h0004;
    localparam logic [SET_W-1:0] TIME_MAX = 16'h7530;
    localparam int CNT_W = 4;
    localparam int NUM_SECT = 6;
    localparam int TOT_W = 5;
    localparam logic [CNT_W-1:0] MAX_FAULTS_RST = 4'h3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int STEP_TIME_NS = 10_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;

    // sector test: |im| * 443 < |re| * 256 means within 30 deg of axis
    localparam int SQRT3_NUM = 443;
    localparam int SQRT3_DEN = 256;

endpackage : ubcl_pkg

// *** tb/ubcl_monitor.sv ***
`timescale 1ns/1ps
module ubcl_monitor
    import ubcl_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sample_valid,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic normal_start,
    input wire logic normal_trip,
    input wire logic location_start,
    input wire logic location_trip
);
    // ****************************************************************
    // helper state
    // ****************************************************************
    logic [1:0] mode_q;
    logic [3:0] off_q;
    int run_q;
    wire clr_w = wr && (addr == REG_CMD || addr == REG_MODE);
    wire odd_w = (addr == REG_CMD) || (addr > REG_COMP_IM);
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mode_q <= 2'h0;
            off_q <= 4'h0;
            run_q <= 0;
        end
        else
        begin
            if (wr && addr == REG_MODE)
                mode_q <= wdata[1:0];
            off_q <= (mode_q != 2'h0) ? 4'h0 : off_q + {3'h0, off_q != 4'hF};
            run_q <= normal_start ? run_q + 1 : 0;
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("rdata not zero outside a read");
    odd_read_a: assert property ($past(rd && odd_w) |->
        rdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    status_read_a: assert property (
        $past(rd && addr == REG_STATUS) |->
        rdata[3:0] == $past({location_trip, location_start, normal_trip,
        normal_start}) && rdata[31:9] == 23'h0)
        else $error("status word does not match outputs");
    off_quiet_a: assert property (off_q > 4'h3 |->
        !normal_start && !location_start)
        else $error("start while mode off");
    // a setting or mode write moves the start off the sample grid
    start_late_a: assert property (
        $rose(normal_start) && !$past(wr, 2) |-> $past(sample_valid, 3))
        else $error("normal start not three cycles after sample");
    trip_hold_a: assert property (
        normal_trip && !clr_w && !$past(clr_w) |=> normal_trip)
        else $error("normal trip dropped without clear");
    loc_hold_a: assert property (
        location_trip && !clr_w && !$past(clr_w) |=> location_trip)
        else $error("location trip dropped without clear");
    trip_time_a: assert property ($rose(normal_trip) |->
        run_q >= 3 * STEP_CYC - 2)
        else $error("normal trip before operate time");
    off_trip_a: assert property ($rose(location_trip) |->
        $past(mode_q) != 2'h0)
        else $error("location trip while mode off");
endmodule : ubcl_monitor

bind ubcl_locator ubcl_monitor #(.STEP_CYC(STEP_CYC)) i_ubcl_monitor (
    .clk(clk), .rstn(rstn), .sample_valid(sample_valid), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .normal_start(normal_start), .normal_trip(normal_trip),
    .location_start(location_start), .location_trip(location_trip));

// *** tb/ubcl_ct_model.sv ***
`timescale 1ns/1ps
module ubcl_ct_model
    import ubcl_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire ubcl_phasor_type u_set,
    input wire ubcl_phasor_type r_set,
    output ubcl_phasor_type unbalance_current_input,
    output ubcl_phasor_type reference_phase_current,
    output logic sample_valid
);
    // ****************************************************************
    // sampling, one pair every four cycles
    // ****************************************************************
    logic [1:0] div_q;
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            div_q <= 2'h0;
            sample_valid <= 1'b0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            sample_valid <= (div_q == 2'h3);
        end
    end
    // stale between samples, inverted so no old value passes
    assign unbalance_current_input = sample_valid ? u_set
        : ubcl_phasor_type'(~u_set);
    assign reference_phase_current = sample_valid ? r_set
        : ubcl_phasor_type'(~r_set);
endmodule : ubcl_ct_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    import ubcl_pkg::*;
    // ****************************************************************
    // signals
    // ****************************************************************
    localparam int LIMIT = 20000;
    localparam logic [15:0] VRE [6] = '{16'h0040, 16'h0020, 16'hFFE0,
        16'hFFC0, 16'hFFE0, 16'h0020};
    localparam logic [15:0] VIM [6] = '{16'h0000, 16'h0037, 16'h0037,
        16'h0000, 16'hFFC9, 16'hFFC9};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sample_valid;
    ubcl_phasor_type unb;
    ubcl_phasor_type refc;
    ubcl_phasor_type u_set = '0;
    ubcl_phasor_type r_set = '0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic normal_start, normal_trip, location_start, location_trip;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    ubcl_locator #(.STEP_CYC(4)) i_ubcl_locator (.clk(clk), .rstn(rstn),
        .unbalance_current_input(unb), .reference_phase_current(refc),
        .sample_valid(sample_valid), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .normal_start(normal_start),
        .normal_trip(normal_trip), .location_start(location_start),
        .location_trip(location_trip));
    ubcl_ct_model i_ubcl_ct_model (.clk(clk), .rstn(rstn), .u_set(u_set),
        .r_set(r_set), .unbalance_current_input(unb),
        .reference_phase_current(refc), .sample_valid(sample_valid));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            complete_run();
        end
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task complete_run;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_chk(input string name, input logic [ADDR_W-1:0] a,
        input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        if (name != "")
            check(name, v, exp);
    endtask : rd_chk
    // polling bounded to 200 reads; the final compare is tagged status, not by the caller
    task wait_stat(input logic [31:0] mask, input logic [31:0] val);
        for (int i = 0; i < 200; i++)
        begin
            rd_chk("", REG_STATUS, 32'h0);
            if ((v & mask) === val)
                break;
        end
        check("status", v & mask, val);
    endtask : wait_stat
    task set_in(input logic [15:0] a, input logic [15:0] b,
        input logic [15:0] c, input logic [15:0] d);
        @(posedge clk);
        u_set <= '{re: a, im: b};
        r_set <= '{re: c, im: d};
        repeat (12) @(posedge clk);
    endtask : set_in
    task fresh_save;
        set_in(16'h0000, 16'h0000, 16'h0100, 16'h0000);
        wr_reg(REG_CMD, 32'h1);
        wr_reg(REG_CMD, 32'h2);
    endtask : fresh_save
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset;
        rd_chk("mode", REG_MODE, 32'h0);
        rd_chk("norm_start", REG_NORM_START, {16'h0, START_MAX});
        rd_chk("loc_time", REG_LOC_TIME, {16'h0, TIME_MAX});
        rd_chk("max_faults", REG_MAX_FAULTS, 32'h3);
        rd_chk("counters", REG_COUNTERS, 32'h0);
        rd_chk("unmapped", 4'hF, 32'h0);
    endtask : t_reset
    task t_clamp;
        wr_reg(REG_LOC_START, 32'h0);
        rd_chk("start_lo", REG_LOC_START, {16'h0, START_MIN});
        wr_reg(REG_LOC_START, 32'hFFFF);
        rd_chk("start_hi", REG_LOC_START, {16'h0, START_MAX});
        wr_reg(REG_NORM_TIME, 32'h1);
        rd_chk("time_lo", REG_NORM_TIME, {16'h0, TIME_MIN});
        wr_reg(REG_NORM_TIME, 32'h7531);
        rd_chk("time_hi", REG_NORM_TIME, {16'h0, TIME_MAX});
    endtask : t_clamp
    task t_normal;
        wr_reg(REG_MODE, 32'h1);
        wr_reg(REG_NORM_START, 32'hA);
        wr_reg(REG_NORM_TIME, 32'h4);
        set_in(16'h0004, 16'h0000, 16'h0100, 16'h0000);
        wr_reg(REG_CMD, 32'h1);
        repeat (12) @(posedge clk);
        rd_chk("comp_zero", REG_COMP_RE, 32'h0);
        set_in(16'h0036, 16'h0000, 16'h0100, 16'h0000);
        rd_chk("comp_re", REG_COMP_RE, 32'h32);
        set_in(16'h0000, 16'h0036, 16'h0000, 16'h0100);
        rd_chk("comp_rot", REG_COMP_RE, 32'h32);
        rd_chk("comp_im", REG_COMP_IM, 32'h0);
        wait_stat(32'h3, 32'h3);
        rd_chk("no_locate", REG_COUNTERS, 32'h0);
        wr_reg(REG_MODE, 32'h0);
        repeat (8) @(posedge clk);
        check("off_start", {31'h0, normal_start}, 32'h0);
        check("off_trip", {31'h0, normal_trip}, 32'h0);
    endtask : t_normal
    task t_sectors;
        wr_reg(REG_MODE, 32'h2);
        wr_reg(REG_LOC_START, 32'hA);
        wr_reg(REG_LOC_TIME, 32'h4);
        for (int k = 0; k < 6; k++)
        begin
            fresh_save();
            set_in(VRE[k], VIM[k], 16'h0100, 16'h0000);
            wait_stat(32'h1F0, 32'h10);
            rd_chk("sect", REG_COUNTERS, 32'h1 << 4 * k);
            repeat (12) @(posedge clk);
            check("rezero", {31'h0, location_start}, 32'h0);
            check("no_trip", {31'h0, location_trip}, 32'h0);
            if (k < 2)
                rd_chk("norm_kept", REG_COMP_RE, {16'h0, VRE[k]});
        end
    endtask : t_sectors
    task t_trip;
        wr_reg(REG_MAX_FAULTS, 32'h2);
        fresh_save();
        for (int n = 1; n < 4; n++)
        begin
            set_in(16'(n) * 16'h0020, 16'(n) * 16'h0037, 16'h0100, 16'h0);
            wait_stat(32'h1F0, 32'(n) << 4);
            repeat (2) @(posedge clk);
            check("loc_trip", {31'h0, location_trip}, 32'(n == 3));
        end
        rd_chk("same_sector", REG_COUNTERS, 32'h30);
        wr_reg(REG_CMD, 32'h2);
        repeat (4) @(posedge clk);
        check("trip_clr", {31'h0, location_trip}, 32'h0);
        rd_chk("cnt_clr", REG_COUNTERS, 32'h0);
    endtask : t_trip
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_clamp();
        t_normal();
        t_sectors();
        t_trip();
        complete_run();
    end
endmodule : tb
